// >>> asou_pkg.sv
// Constants, field positions and reset values of the alarm, status and offset unit.
// Assumes a host-side serial port decoder that delivers register indices and 16-bit words.
package asou_pkg;
	// Register indices
	localparam logic [3:0] IDX_X_ACCEL_NULL = 4'h0;
	localparam logic [3:0] IDX_Y_ACCEL_NULL = 4'h1;
	localparam logic [3:0] IDX_X_TILT_NULL = 4'h2;
	localparam logic [3:0] IDX_Y_TILT_NULL = 4'h3;
	localparam logic [3:0] IDX_ROTATION_OFFSET_NULL = 4'h4;
	localparam logic [3:0] IDX_ALARM_CFG = 4'h5;
	localparam logic [3:0] IDX_ALARM_ONE_THR = 4'h6;
	localparam logic [3:0] IDX_ALARM_TWO_THR = 4'h7;
	localparam logic [3:0] IDX_ALARM_ONE_CNT = 4'h8;
	localparam logic [3:0] IDX_ALARM_TWO_CNT = 4'h9;
	localparam logic [3:0] IDX_ERROR_FLAGS = 4'hA;
	localparam logic [3:0] IDX_COMMAND = 4'hB;
	// Write masks and reset values
	localparam logic [15:0] NULL_MASK = 16'h3FFF;
	localparam logic [15:0] THR_MASK = 16'hBFFF;
	localparam logic [15:0] CNT_MASK = 16'h00FF;
	localparam logic [15:0] CFG_MASK = 16'hFF7F;
	localparam logic [15:0] NULL_RESET = 16'h0000;
	localparam logic [15:0] THR_RESET = 16'h0000;
	localparam logic [15:0] CNT_RESET = 16'h0001;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	// Field positions
	localparam int THR_GT_BIT = 15;
	localparam int CFG_SRC_TWO_LSB = 12;
	localparam int CFG_SRC_ONE_LSB = 8;
	localparam int CFG_RATE_TWO_BIT = 6;
	localparam int CFG_RATE_ONE_BIT = 5;
	localparam int CFG_FILT_TWO_BIT = 4;
	localparam int CFG_FILT_ONE_BIT = 3;
	localparam int CFG_IND_EN_BIT = 2;
	localparam int CFG_IND_POL_BIT = 1;
	localparam int CFG_IND_SEL_BIT = 0;
	localparam int ST_ALARM_TWO_BIT = 9;
	localparam int ST_ALARM_ONE_BIT = 8;
	localparam int ST_SELFTEST_BIT = 5;
	localparam int ST_LINK_BIT = 3;
	localparam int ST_FLASH_BIT = 2;
	localparam int ST_SUPPLY_HIGH_BIT = 1;
	localparam int ST_SUPPLY_LOW_BIT = 0;
	localparam int CMD_CLEAR_BIT = 4;
	localparam int CMD_RESTORE_BIT = 1;
	// Source codes
	localparam logic [3:0] SRC_DISABLED = 4'h0;
	localparam logic [3:0] SRC_SUPPLY = 4'h1;
	localparam logic [3:0] SRC_X_TILT = 4'h6;
	localparam logic [3:0] SRC_Y_TILT = 4'h7;
	localparam logic [3:0] SRC_ROTATION = 4'h8;
	// Supply limits in supply-output codes: 3.625 V and 2.975 V
	localparam logic [13:0] SUPPLY_HIGH_CODE = 14'h0E80;
	localparam logic [13:0] SUPPLY_LOW_CODE = 14'h0BE6;
endpackage

// >>> asou_alarm_chan.sv
// One alarm comparator channel: static or rate-of-change evaluation of one source.
// Assumes a one-cycle sample strobe and a value already selected and filtered upstream.
`timescale 1ns/1ns
module asou_alarm_chan (
	input wire logic i_ref_clk, // System clock
	input wire logic i_resetn, // Async reset, active low
	input wire logic i_sample, // New output sample strobe
	input wire logic [13:0] i_value, // Selected sample value
	input wire logic i_enable, // Source not disabled
	input wire logic i_rate_mode, // Rate-of-change evaluation
	input wire logic [15:0] i_thresh, // Threshold register
	input wire logic [7:0] i_count, // Sample count field
	output logic o_active, // Latest comparison result
	output logic o_eval // Pulse: result refreshed
);
	typedef struct packed {
		logic [13:0] prev;
		logic have_prev;
		logic signed [24:0] acc;
		logic [7:0] cnt;
		logic active;
		logic eval;
	} asou_chan_t;

	asou_chan_t st_reg;
	asou_chan_t st_next;
	logic [7:0] n_eff;
	logic signed [24:0] diff;
	logic signed [24:0] sum;
	logic signed [24:0] lim;

	// Compare in threshold polarity
	function automatic logic trip(input logic gt, input logic signed [24:0] a, input logic signed [24:0] b);
		trip = gt ? (a > b) : (a < b);
	endfunction

	// Effective count and window arithmetic
	always_comb begin
		n_eff = (i_count <= 8'h01) ? 8'h01 : i_count;
		diff = 25'($signed(i_value)) - 25'($signed(st_reg.prev));
		sum = st_reg.acc + diff;
		lim = 25'($signed(i_thresh[13:0])) * 25'($signed({1'b0, n_eff}));
	end

	// Evaluation per sample
	always_comb begin
		st_next = st_reg;
		st_next.eval = 1'b0;
		if (!i_enable) begin
			st_next = '0;
		end else if (i_sample) begin
			if (!i_rate_mode) begin
				st_next.active = trip(i_thresh[asou_pkg::THR_GT_BIT], 25'($signed(i_value)),
					25'($signed(i_thresh[13:0])));
				st_next.eval = 1'b1;
				st_next.have_prev = 1'b0;
				st_next.acc = '0;
				st_next.cnt = 8'h00;
			end else if (!st_reg.have_prev) begin
				st_next.prev = i_value;
				st_next.have_prev = 1'b1;
				st_next.acc = '0;
				st_next.cnt = 8'h00;
			end else begin
				st_next.prev = i_value;
				if (st_reg.cnt + 8'h01 >= n_eff) begin
					// Mean of differences vs threshold, scaled by count to avoid division
					st_next.active = trip(i_thresh[asou_pkg::THR_GT_BIT], sum, lim);
					st_next.eval = 1'b1;
					st_next.acc = '0;
					st_next.cnt = 8'h00;
				end else begin
					st_next.acc = sum;
					st_next.cnt = st_reg.cnt + 8'h01;
				end
			end
		end
	end

	// State register
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_active = st_reg.active;
	assign o_eval = st_reg.eval;

	a_static_compare: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_enable && !i_rate_mode && i_sample |=> o_eval && (o_active == ($past(i_thresh[15]) ?
		($signed($past(i_value)) > $signed($past(i_thresh[13:0]))) :
		($signed($past(i_value)) < $signed($past(i_thresh[13:0]))))))
		else $error("static alarm result wrong");
	a_disabled_idle: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		!i_enable |=> !o_active && !o_eval)
		else $error("disabled channel not idle");
	a_count_one: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_enable && i_rate_mode && i_count <= 8'h01 && i_sample && st_reg.have_prev |=> o_eval)
		else $error("count of one did not evaluate each sample");
	c_rate_trip: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_rate_mode && o_eval && o_active);
endmodule

// >>> asou_top.sv
// Alarm, status and offset-null register unit of a dual-axis inclinometer.
// Assumes a serial port decoder on the same clock delivering index, data and strobes,
// and a sampling engine giving a one-cycle sample strobe with raw and filtered data.
`timescale 1ns/1ns
module asou_top (
	input wire logic i_ref_clk, // 100 MHz clock
	input wire logic i_resetn, // Async reset, active low
	input wire logic i_reg_wr, // Register write strobe
	input wire logic i_reg_rd, // Register read strobe
	input wire logic [3:0] i_reg_idx, // Register index
	input wire logic [15:0] i_reg_wdata, // Write data
	output logic [15:0] o_reg_rdata, // Read data, one cycle after strobe
	input wire logic i_sample_valid, // New output sample
	input wire logic [8:0][13:0] i_raw_data, // Unfiltered data by source code
	input wire logic [8:0][13:0] i_filt_data, // Filtered data by source code
	input wire logic i_selftest_err, // Self-test error event
	input wire logic i_link_err, // Serial link error event
	input wire logic i_flash_err, // Flash update failed event
	output logic [13:0] o_x_accel_offset_null, // Offset value
	output logic [13:0] o_y_accel_offset_null, // Offset value
	output logic [13:0] o_x_tilt_offset_null, // Offset value
	output logic [13:0] o_y_tilt_offset_null, // Offset value
	output logic [13:0] o_rotation_offset_null, // Offset value
	output logic o_first_general_line, // Indicator level
	output logic o_first_general_line_oe, // Indicator drives line
	output logic o_second_general_line, // Indicator level
	output logic o_second_general_line_oe // Indicator drives line
);
	typedef struct packed {
		logic [4:0][13:0] nulls;
		logic [15:0] cfg;
		logic [1:0][15:0] thr;
		logic [1:0][7:0] cnt;
		logic [15:0] status;
		logic [15:0] rdata;
		logic [1:0] line_out;
		logic [1:0] line_oe;
	} asou_state_t;

	asou_state_t st_reg;
	asou_state_t st_next;
	logic [1:0] ch_active;
	logic [1:0] ch_eval;
	logic [1:0][13:0] ch_value;
	logic [1:0][3:0] ch_src;
	logic [1:0] ch_enable;
	logic [1:0] ch_rate;
	logic [1:0] ch_filt;
	logic wr_cmd_clear;
	logic ind_level;

	// Angle sources always use filtered data
	function automatic logic is_angle(input logic [3:0] src);
		is_angle = (src == asou_pkg::SRC_X_TILT) || (src == asou_pkg::SRC_Y_TILT) ||
			(src == asou_pkg::SRC_ROTATION);
	endfunction

	// Value seen by a channel for a source and filter choice
	function automatic logic [13:0] pick(input logic [3:0] src, input logic filt,
		input logic [8:0][13:0] raw, input logic [8:0][13:0] flt);
		logic [3:0] s;
		s = (src > asou_pkg::SRC_ROTATION) ? asou_pkg::SRC_DISABLED : src;
		pick = (filt || is_angle(s)) ? flt[s] : raw[s];
	endfunction

	// Per-channel configuration decode
	always_comb begin
		ch_src[0] = st_reg.cfg[asou_pkg::CFG_SRC_ONE_LSB +: 4];
		ch_src[1] = st_reg.cfg[asou_pkg::CFG_SRC_TWO_LSB +: 4];
		ch_rate[0] = st_reg.cfg[asou_pkg::CFG_RATE_ONE_BIT];
		ch_rate[1] = st_reg.cfg[asou_pkg::CFG_RATE_TWO_BIT];
		ch_filt[0] = st_reg.cfg[asou_pkg::CFG_FILT_ONE_BIT];
		ch_filt[1] = st_reg.cfg[asou_pkg::CFG_FILT_TWO_BIT];
		for (int i = 0; i < 2; i++) begin
			ch_enable[i] = (ch_src[i] != asou_pkg::SRC_DISABLED) && (ch_src[i] <= asou_pkg::SRC_ROTATION);
			ch_value[i] = pick(ch_src[i], ch_filt[i], i_raw_data, i_filt_data);
		end
		wr_cmd_clear = i_reg_wr && (i_reg_idx == asou_pkg::IDX_COMMAND) &&
			i_reg_wdata[asou_pkg::CMD_CLEAR_BIT];
		ind_level = (ch_active[0] || ch_active[1]) ~^ st_reg.cfg[asou_pkg::CFG_IND_POL_BIT];
	end

	// Two independent comparator channels
	asou_alarm_chan u_chan_one (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_sample(i_sample_valid),
		.i_value(ch_value[0]),
		.i_enable(ch_enable[0]),
		.i_rate_mode(ch_rate[0]),
		.i_thresh(st_reg.thr[0]),
		.i_count(st_reg.cnt[0]),
		.o_active(ch_active[0]),
		.o_eval(ch_eval[0])
	);
	asou_alarm_chan u_chan_two (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_sample(i_sample_valid),
		.i_value(ch_value[1]),
		.i_enable(ch_enable[1]),
		.i_rate_mode(ch_rate[1]),
		.i_thresh(st_reg.thr[1]),
		.i_count(st_reg.cnt[1]),
		.o_active(ch_active[1]),
		.o_eval(ch_eval[1])
	);

	// Register writes, status flags, read data and indicator lines
	always_comb begin
		st_next = st_reg;
		// Host writes
		if (i_reg_wr) begin
			case (i_reg_idx)
				asou_pkg::IDX_X_ACCEL_NULL: st_next.nulls[0] = i_reg_wdata[13:0];
				asou_pkg::IDX_Y_ACCEL_NULL: st_next.nulls[1] = i_reg_wdata[13:0];
				asou_pkg::IDX_X_TILT_NULL: st_next.nulls[2] = i_reg_wdata[13:0];
				asou_pkg::IDX_Y_TILT_NULL: st_next.nulls[3] = i_reg_wdata[13:0];
				asou_pkg::IDX_ROTATION_OFFSET_NULL: st_next.nulls[4] = i_reg_wdata[13:0];
				asou_pkg::IDX_ALARM_CFG: st_next.cfg = i_reg_wdata & asou_pkg::CFG_MASK;
				asou_pkg::IDX_ALARM_ONE_THR: st_next.thr[0] = i_reg_wdata & asou_pkg::THR_MASK;
				asou_pkg::IDX_ALARM_TWO_THR: st_next.thr[1] = i_reg_wdata & asou_pkg::THR_MASK;
				asou_pkg::IDX_ALARM_ONE_CNT: st_next.cnt[0] = i_reg_wdata[7:0];
				asou_pkg::IDX_ALARM_TWO_CNT: st_next.cnt[1] = i_reg_wdata[7:0];
				asou_pkg::IDX_COMMAND: begin
					if (i_reg_wdata[asou_pkg::CMD_RESTORE_BIT]) begin
						st_next.nulls = {5{asou_pkg::NULL_RESET[13:0]}};
					end
				end
				default: st_next.cfg = st_reg.cfg;
			endcase
		end
		// Clears first, so events below win over them
		if (wr_cmd_clear) begin
			st_next.status = asou_pkg::STATUS_RESET;
		end
		if (i_reg_rd && (i_reg_idx == asou_pkg::IDX_ERROR_FLAGS)) begin
			st_next.status[asou_pkg::ST_FLASH_BIT] = 1'b0;
		end
		// Sticky error events
		if (i_selftest_err) begin
			st_next.status[asou_pkg::ST_SELFTEST_BIT] = 1'b1;
		end
		if (i_link_err) begin
			st_next.status[asou_pkg::ST_LINK_BIT] = 1'b1;
		end
		if (i_flash_err) begin
			st_next.status[asou_pkg::ST_FLASH_BIT] = 1'b1;
		end
		// Supply levels, refreshed every sample from filtered supply
		if (i_sample_valid) begin
			st_next.status[asou_pkg::ST_SUPPLY_HIGH_BIT] =
				i_filt_data[asou_pkg::SRC_SUPPLY] > asou_pkg::SUPPLY_HIGH_CODE;
			st_next.status[asou_pkg::ST_SUPPLY_LOW_BIT] =
				i_filt_data[asou_pkg::SRC_SUPPLY] < asou_pkg::SUPPLY_LOW_CODE;
		end
		// Alarm status follows each fresh result
		if (ch_eval[0] || !ch_enable[0]) begin
			st_next.status[asou_pkg::ST_ALARM_ONE_BIT] = ch_active[0];
		end
		if (ch_eval[1] || !ch_enable[1]) begin
			st_next.status[asou_pkg::ST_ALARM_TWO_BIT] = ch_active[1];
		end
		// Read data
		st_next.rdata = 16'h0000;
		if (i_reg_rd) begin
			case (i_reg_idx)
				asou_pkg::IDX_X_ACCEL_NULL: st_next.rdata = {2'b00, st_reg.nulls[0]};
				asou_pkg::IDX_Y_ACCEL_NULL: st_next.rdata = {2'b00, st_reg.nulls[1]};
				asou_pkg::IDX_X_TILT_NULL: st_next.rdata = {2'b00, st_reg.nulls[2]};
				asou_pkg::IDX_Y_TILT_NULL: st_next.rdata = {2'b00, st_reg.nulls[3]};
				asou_pkg::IDX_ROTATION_OFFSET_NULL: st_next.rdata = {2'b00, st_reg.nulls[4]};
				asou_pkg::IDX_ALARM_CFG: st_next.rdata = st_reg.cfg;
				asou_pkg::IDX_ALARM_ONE_THR: st_next.rdata = st_reg.thr[0];
				asou_pkg::IDX_ALARM_TWO_THR: st_next.rdata = st_reg.thr[1];
				asou_pkg::IDX_ALARM_ONE_CNT: st_next.rdata = {8'h00, st_reg.cnt[0]};
				asou_pkg::IDX_ALARM_TWO_CNT: st_next.rdata = {8'h00, st_reg.cnt[1]};
				asou_pkg::IDX_ERROR_FLAGS: st_next.rdata = st_reg.status;
				default: st_next.rdata = 16'h0000;
			endcase
		end
		// Indicator on the chosen general line
		st_next.line_out = 2'b00;
		st_next.line_oe = 2'b00;
		if (st_reg.cfg[asou_pkg::CFG_IND_EN_BIT]) begin
			st_next.line_oe[st_reg.cfg[asou_pkg::CFG_IND_SEL_BIT]] = 1'b1;
			st_next.line_out[st_reg.cfg[asou_pkg::CFG_IND_SEL_BIT]] = ind_level;
		end
	end

	// State register
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_reg.nulls <= {5{asou_pkg::NULL_RESET[13:0]}};
			st_reg.cfg <= asou_pkg::CFG_RESET;
			st_reg.thr <= {asou_pkg::THR_RESET, asou_pkg::THR_RESET};
			st_reg.cnt <= {asou_pkg::CNT_RESET[7:0], asou_pkg::CNT_RESET[7:0]};
			st_reg.status <= asou_pkg::STATUS_RESET;
			st_reg.rdata <= 16'h0000;
			st_reg.line_out <= 2'b00;
			st_reg.line_oe <= 2'b00;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign o_reg_rdata = st_reg.rdata;
	assign o_x_accel_offset_null = st_reg.nulls[0];
	assign o_y_accel_offset_null = st_reg.nulls[1];
	assign o_x_tilt_offset_null = st_reg.nulls[2];
	assign o_y_tilt_offset_null = st_reg.nulls[3];
	assign o_rotation_offset_null = st_reg.nulls[4];
	assign o_first_general_line = st_reg.line_out[0];
	assign o_first_general_line_oe = st_reg.line_oe[0];
	assign o_second_general_line = st_reg.line_out[1];
	assign o_second_general_line_oe = st_reg.line_oe[1];

	a_null_readback: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_reg_rd && i_reg_idx == asou_pkg::IDX_X_ACCEL_NULL
		|=> o_reg_rdata == {2'b00, $past(o_x_accel_offset_null)})
		else $error("offset readback wrong");
	// A disabled channel may still show its last result for one cycle, so exclude that case
	a_status_clear: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		wr_cmd_clear && !i_selftest_err && !i_link_err && !i_flash_err && !i_sample_valid
		&& !ch_eval[0] && !ch_eval[1] && (ch_active & ~ch_enable) == 2'b00
		|=> st_reg.status == 16'h0000)
		else $error("status not cleared by command");
	a_flash_read_clear: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_reg_rd && i_reg_idx == asou_pkg::IDX_ERROR_FLAGS && !i_flash_err
		|=> !st_reg.status[asou_pkg::ST_FLASH_BIT])
		else $error("flash flag not cleared by status read");
	a_selftest_set: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_selftest_err |=> st_reg.status[asou_pkg::ST_SELFTEST_BIT])
		else $error("self-test flag lost");
	a_link_set: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_link_err ##1 !wr_cmd_clear |=> st_reg.status[asou_pkg::ST_LINK_BIT])
		else $error("link flag lost");
	a_supply_low: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_sample_valid |=> st_reg.status[asou_pkg::ST_SUPPLY_LOW_BIT] ==
		($past(i_filt_data[asou_pkg::SRC_SUPPLY]) < asou_pkg::SUPPLY_LOW_CODE))
		else $error("low supply flag wrong");
	a_supply_high: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_sample_valid |=> st_reg.status[asou_pkg::ST_SUPPLY_HIGH_BIT] ==
		($past(i_filt_data[asou_pkg::SRC_SUPPLY]) > asou_pkg::SUPPLY_HIGH_CODE))
		else $error("high supply flag wrong");
	a_line_select: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		st_reg.cfg[asou_pkg::CFG_IND_EN_BIT] && !st_reg.cfg[asou_pkg::CFG_IND_SEL_BIT] && !i_reg_wr
		|=> o_first_general_line_oe && !o_second_general_line_oe)
		else $error("indicator on wrong line");
	a_alarm_status: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		ch_eval[0] |=> st_reg.status[asou_pkg::ST_ALARM_ONE_BIT] == $past(ch_active[0]))
		else $error("alarm one status stale");
	c_alarm_line: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
		st_reg.status[9] && o_second_general_line_oe);
	c_clear_then_set: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
		wr_cmd_clear && i_flash_err);
	c_both_alarms: cover property (@(posedge i_ref_clk) disable iff (!i_resetn)
		st_reg.status[9:8] == 2'b11);
endmodule

// >>> asou_host_model.sv
// Host processor model: drives register strobes of the unit at the falling clock edge.
// Assumes read data is registered and valid the cycle after a read strobe.
`timescale 1ns/1ns
module asou_host_model (
	input wire logic i_ref_clk, // System clock
	input wire logic [15:0] i_reg_rdata, // Read data from unit
	output logic o_reg_wr, // Write strobe
	output logic o_reg_rd, // Read strobe
	output logic [3:0] o_reg_idx, // Register index
	output logic [15:0] o_reg_wdata // Write data
);
	// Idle bus at time zero
	initial begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_idx = 4'h0;
		o_reg_wdata = 16'h0000;
	end
	// One-cycle write; released fields are inverted so stale values never match
	task automatic wr(input logic [3:0] i, input logic [15:0] d);
		@(negedge i_ref_clk);
		o_reg_wr = 1'b1;
		o_reg_idx = i;
		o_reg_wdata = d;
		@(negedge i_ref_clk);
		o_reg_wr = 1'b0;
		o_reg_idx = ~i;
		o_reg_wdata = ~d;
	endtask
	// One-cycle read; data taken in the cycle after the strobe
	task automatic rd(input logic [3:0] i, output logic [15:0] q);
		@(negedge i_ref_clk);
		o_reg_rd = 1'b1;
		o_reg_idx = i;
		@(negedge i_ref_clk);
		q = i_reg_rdata;
		o_reg_rd = 1'b0;
		o_reg_idx = ~i;
	endtask
endmodule

// >>> alarm_status_offset_unit_bench.sv
// Self-checking bench of the alarm, status and offset unit.
// Assumes the host model above and a free 100 MHz clock; inputs change at the falling edge.
`timescale 1ns/1ns
module alarm_status_offset_unit_bench;
	logic i_ref_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic sv = 1'b0;
	logic st_err = 1'b0;
	logic ln_err = 1'b0;
	logic fl_err = 1'b0;
	logic [8:0][13:0] raw = '0;
	logic [8:0][13:0] flt = '0;
	logic wr, rd, l1, l1oe, l2, l2oe;
	logic [3:0] idx;
	logic [15:0] wd, rdata, q;
	logic [13:0] nx, ny, xt, yt, rn;
	int fails = 0;
	int samples_checked = 0;
	// Clock
	always #5 i_ref_clk = ~i_ref_clk;
	asou_host_model host (.i_ref_clk(i_ref_clk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd),
		.o_reg_idx(idx), .o_reg_wdata(wd));
	asou_top dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_idx(idx), .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_sample_valid(sv),
		.i_raw_data(raw), .i_filt_data(flt), .i_selftest_err(st_err), .i_link_err(ln_err),
		.i_flash_err(fl_err), .o_x_accel_offset_null(nx), .o_y_accel_offset_null(ny),
		.o_x_tilt_offset_null(xt), .o_y_tilt_offset_null(yt), .o_rotation_offset_null(rn),
		.o_first_general_line(l1), .o_first_general_line_oe(l1oe),
		.o_second_general_line(l2), .o_second_general_line_oe(l2oe));
	// Compare and count
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [3:0] i, input logic [15:0] e);
		host.rd(i, q);
		chk($sformatf("reg%0d", i), e, q);
	endtask
	// One sample strobe, then let the result reach status and lines
	task automatic sample();
		@(negedge i_ref_clk) sv = 1'b1;
		@(negedge i_ref_clk) sv = 1'b0;
		repeat (3) @(negedge i_ref_clk);
	endtask
	task automatic t_reset();
		for (int i = 0; i < 5; i++) rchk(4'(i), 16'h0000);
		rchk(4'h5, 16'h0000);
		rchk(4'h6, 16'h0000);
		rchk(4'h8, 16'h0001);
		rchk(4'h9, 16'h0001);
		rchk(4'hA, 16'h0000);
		$display("reset values done");
	endtask
	task automatic t_mask();
		// Skip the command index so its restore bit does not wipe the nulls
		for (int i = 0; i < 16; i++) begin
			if (i != 11) begin
				host.wr(4'(i), 16'hFFFF);
			end
		end
		for (int i = 0; i < 5; i++) rchk(4'(i), 16'h3FFF);
		chk("x accel null", 16'h3FFF, {2'b00, nx});
		chk("y accel null", 16'h3FFF, {2'b00, ny});
		chk("x tilt null", 16'h3FFF, {2'b00, xt});
		chk("y tilt null", 16'h3FFF, {2'b00, yt});
		chk("rotation null", 16'h3FFF, {2'b00, rn});
		rchk(4'h5, 16'hFF7F);
		rchk(4'h7, 16'hBFFF);
		rchk(4'h9, 16'h00FF);
		rchk(4'hC, 16'h0000);
		// Restore command returns every null to its reset value
		host.wr(4'hB, 16'h0002);
		for (int i = 0; i < 5; i++) rchk(4'(i), 16'h0000);
		chk("rotation null", 16'h0000, {2'b00, rn});
		$display("field masks done");
	endtask
	task automatic t_static();
		host.wr(4'h8, 16'h0001);
		host.wr(4'h9, 16'h0000);
		host.wr(4'h6, 16'h8064);
		host.wr(4'h5, 16'h0206);
		raw[2] = 14'h00C8;
		flt[2] = 14'h0000;
		sample();
		rchk(4'hA, 16'h0100);
		chk("line one", 16'h0003, {12'h000, l2oe, l2, l1oe, l1});
		raw[2] = 14'h0032;
		sample();
		rchk(4'hA, 16'h0000);
		chk("line one", 16'h0002, {12'h000, l2oe, l2, l1oe, l1});
		$display("static alarm done");
	endtask
	task automatic t_filter();
		host.wr(4'h7, 16'h0032);
		host.wr(4'h5, 16'h6205);
		flt[6] = 14'h0064;
		sample();
		rchk(4'hA, 16'h0000);
		flt[6] = 14'h000A;
		raw[2] = 14'h00C8;
		sample();
		rchk(4'hA, 16'h0300);
		chk("line two", 16'h0008, {12'h000, l2oe, l2, l1oe, l1});
		$display("filter select done");
	endtask
	task automatic t_rate();
		host.wr(4'h5, 16'h0200);
		raw[2] = 14'h0000;
		sample();
		host.wr(4'h8, 16'h0002);
		host.wr(4'h6, 16'h8005);
		host.wr(4'h5, 16'h0220);
		sample();
		raw[2] = 14'h000A;
		sample();
		rchk(4'hA, 16'h0000);
		raw[2] = 14'h0014;
		sample();
		rchk(4'hA, 16'h0100);
		raw[2] = 14'h0018;
		sample();
		raw[2] = 14'h001C;
		sample();
		rchk(4'hA, 16'h0000);
		// Channel two, count zero: one difference per evaluation, less-than sense
		host.wr(4'h5, 16'h5040);
		raw[5] = 14'h0064;
		sample();
		raw[5] = 14'h006E;
		sample();
		rchk(4'hA, 16'h0200);
		$display("rate alarm done");
	endtask
	task automatic t_status();
		host.wr(4'h5, 16'h0000);
		host.wr(4'hB, 16'h0010);
		@(negedge i_ref_clk) {st_err, ln_err, fl_err} = 3'b111;
		@(negedge i_ref_clk) {st_err, ln_err, fl_err} = 3'b000;
		flt[1] = 14'h0E81;
		sample();
		rchk(4'hA, 16'h002E);
		rchk(4'hA, 16'h002A);
		host.wr(4'hB, 16'h0010);
		rchk(4'hA, 16'h0000);
		flt[1] = 14'h0E80;
		sample();
		rchk(4'hA, 16'h0000);
		flt[1] = 14'h0BE5;
		sample();
		rchk(4'hA, 16'h0001);
		flt[1] = 14'h0BE6;
		sample();
		rchk(4'hA, 16'h0000);
		$display("status flags done");
	endtask
	// Verdict and end of run
	task automatic complete_run();
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		flt[1] = 14'h0D00; // Supply inside both limits
		repeat (2) @(negedge i_ref_clk);
		i_resetn = 1'b1;
		t_reset();
		t_mask();
		t_static();
		t_filter();
		t_rate();
		t_status();
		complete_run();
	end
	// Hang guard
	initial begin
		#200000;
		fails++;
		complete_run();
	end
endmodule
